// >>> cit_sequencer.sv
// Instruction timing sequencer: fetch, length and clock count per opcode
//
// Overview of operation
// - Bank register ALU ops: 1 byte, 1 clock
// - Direct byte ALU ops: 2 bytes, 2 clocks
// - Indirect source ALU ops: 1 byte, 2 clocks
// - Immediate ALU ops: 2 bytes, 2 clocks
// - Logic into direct: immediate 3/3, accumulator 2/2
// - Accumulator-only ops: 1 byte, 1 clock
// - Direct to direct move: 3 bytes, 3 clocks
// - Pointer load 3/3, pointer increment 1/1
// - Code byte move: 1 byte, 3 clocks
// - External data moves: 1 byte, 3 clocks
// - External data moves go to external interface
// - Push and pop: 2 bytes, 2 clocks
// - Indirect exchanges: 1 byte, 2 clocks
// - Bank register exchange takes one clock
// - Stores to indirect RAM: 1/2 or 2/2
// - Indirect to direct copy: 2 bytes, 2 clocks
// - Durations counted in plain system clocks
`timescale 1ns/1ps
module cit_sequencer (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Program memory, answers within the cycle
   output logic [15:0] code_addr,
   output logic code_rd,
   input wire logic [7:0] code_byte,
   // Datapath values
   input wire logic [7:0] acc_value,
   input wire logic [7:0] idx_value,
   // External memory interface
   output logic [15:0] xdata_addr,
   output logic xdata_rd,
   output logic xdata_wr,
   output logic [7:0] xdata_wdata,
   input wire logic [7:0] xdata_rdata,
   // Decoded instruction
   output logic [7:0] instr_opcode,
   output logic [7:0] instr_operand1,
   output logic [7:0] instr_operand2,
   output logic [1:0] instr_len,
   output logic [3:0] instr_cycles,
   output cit_pkg::cit_class_t instr_class,
   output logic instr_known,
   // Progress
   output logic instr_start,
   output logic instr_done,
   output logic [3:0] cycle_index,
   // Results
   output logic [15:0] data_pointer,
   output logic acc_load,
   output logic [7:0] acc_load_data
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   // Sequencer state
   cit_pkg::cit_state_t state;
   cit_pkg::cit_state_t next_state;

   // Clocks left, current one included
   logic [3:0] cyc_left;
   logic [3:0] next_cyc_left;

   // Operand bytes still to fetch
   logic [1:0] byte_left;
   logic [1:0] next_byte_left;

   // Address of the next program byte
   logic [15:0] pc;
   logic [15:0] next_pc;

   // Class of the instruction in execution
   cit_pkg::cit_class_t cur_cls;
   cit_pkg::cit_class_t next_cls;

   // Fetch address for the following cycle
   logic [15:0] next_code_addr;
   logic next_code_rd;

   // Cycle index for the following cycle
   logic [3:0] next_step;

   // This cycle ends the instruction
   logic last_cycle;

   // This cycle fetches an operand byte
   logic operand_fetch;

   // Decoder results for the byte on code_byte
   logic [1:0] dec_len;
   logic [3:0] dec_cycles;
   cit_pkg::cit_class_t dec_cls;
   logic dec_known;

   // External access start, decided in the opcode cycle
   logic xd_start;
   logic xd_write;
   logic xd_wide;

   // Base for the code byte move address
   logic [15:0] code_base;

   ////////////////////////////////////////////////////////////////////////////
   // Decoder sees the opcode byte only in an opcode cycle

   cit_opcode_decode u_decode (
      .opcode (code_byte),
      .len (dec_len),
      .cycles (dec_cycles),
      .cls (dec_cls),
      .known (dec_known)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer next state; ST_EXEC holds until its last clock, single clock forms stay in ST_OPCODE
   always_comb begin
      next_state = state;
      next_cyc_left = cyc_left;
      next_byte_left = byte_left;
      next_pc = pc;
      next_cls = cur_cls;
      next_step = cycle_index;
      last_cycle = 1'b0;
      operand_fetch = 1'b0;
      case (state)
         // Opcode cycle counts as the first clock
         cit_pkg::ST_OPCODE: begin
            next_pc = pc + cit_pkg::ADDR_STEP;
            next_cls = dec_cls;
            if (dec_cycles == cit_pkg::CYC_1) begin
               // Single clock forms end here
               last_cycle = 1'b1;
               next_step = cit_pkg::STEP_FIRST;
            end else begin
               next_state = cit_pkg::ST_EXEC;
               next_cyc_left = dec_cycles - cit_pkg::CYC_1;
               next_byte_left = dec_len - cit_pkg::LEN_1;
               next_step = cit_pkg::STEP_ACCESS;
            end
         end
         // Operand bytes come first, then idle or access clocks
         cit_pkg::ST_EXEC: begin
            if (byte_left != 2'h0) begin
               operand_fetch = 1'b1;
               next_pc = pc + cit_pkg::ADDR_STEP;
               next_byte_left = byte_left - cit_pkg::LEN_1;
            end
            next_cyc_left = cyc_left - cit_pkg::CYC_1;
            next_step = cycle_index + cit_pkg::STEP_FIRST;
            if (cyc_left == cit_pkg::CYC_1) begin
               // Next clock is the next opcode fetch
               last_cycle = 1'b1;
               next_state = cit_pkg::ST_OPCODE;
               next_step = cit_pkg::STEP_FIRST;
            end
         end
         // Illegal code recovers to a fetch
         default: begin
            next_state = cit_pkg::ST_OPCODE;
            next_step = cit_pkg::STEP_FIRST;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Code byte move base: pointer or following address
   always_comb begin
      if (dec_cls == cit_pkg::CL_CODE_PC) begin
         code_base = pc + cit_pkg::ADDR_STEP;
      end else begin
         code_base = data_pointer;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Program memory address for the next clock
   always_comb begin
      next_code_addr = next_pc;
      next_code_rd = 1'b1;
      if (state == cit_pkg::ST_OPCODE &&
          (dec_cls == cit_pkg::CL_CODE_PTR || dec_cls == cit_pkg::CL_CODE_PC)) begin
         // Second clock reads the table byte
         next_code_addr = {cit_pkg::PAGE_ZERO, acc_value} + code_base;
      end else if (next_state == cit_pkg::ST_EXEC && next_byte_left == 2'h0) begin
         // Internal clock, memory left quiet
         next_code_rd = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // External request decided in the opcode clock
   always_comb begin
      xd_start = 1'b0;
      xd_write = 1'b0;
      xd_wide = 1'b0;
      if (state == cit_pkg::ST_OPCODE) begin
         case (dec_cls)
            cit_pkg::CL_XRD_IDX: xd_start = 1'b1;
            cit_pkg::CL_XRD_PTR: begin
               xd_start = 1'b1;
               xd_wide = 1'b1;
            end
            cit_pkg::CL_XWR_IDX: begin
               xd_start = 1'b1;
               xd_write = 1'b1;
            end
            cit_pkg::CL_XWR_PTR: begin
               xd_start = 1'b1;
               xd_write = 1'b1;
               xd_wide = 1'b1;
            end
            default: xd_start = 1'b0;
         endcase
      end
   end

   // Strobe lands in the second clock
   cit_xdata_port u_xdata (
      .clk (clk),
      .sys_rst (sys_rst),
      .start (xd_start),
      .write (xd_write),
      .wide (xd_wide),
      .idx_value (idx_value),
      .pointer (data_pointer),
      .wdata_in (acc_value),
      .xdata_addr (xdata_addr),
      .xdata_rd (xdata_rd),
      .xdata_wr (xdata_wr),
      .xdata_wdata (xdata_wdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= cit_pkg::ST_OPCODE;
         cyc_left <= cit_pkg::CYC_1;
         byte_left <= 2'h0;
         pc <= cit_pkg::RESET_PC;
         cur_cls <= cit_pkg::CL_PLAIN;
         cycle_index <= cit_pkg::STEP_FIRST;
      end else begin
         state <= next_state;
         cyc_left <= next_cyc_left;
         byte_left <= next_byte_left;
         pc <= next_pc;
         cur_cls <= next_cls;
         cycle_index <= next_step;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Program memory port; first fetch follows reset release directly
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         code_addr <= cit_pkg::RESET_PC;
         code_rd <= 1'b1;
      end else begin
         code_addr <= next_code_addr;
         code_rd <= next_code_rd;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decoded instruction, captured at the end of its opcode clock
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         instr_opcode <= cit_pkg::RESET_BYTE;
         instr_len <= cit_pkg::LEN_1;
         instr_cycles <= cit_pkg::CYC_1;
         instr_class <= cit_pkg::CL_PLAIN;
         instr_known <= 1'b0;
      end else if (state == cit_pkg::ST_OPCODE) begin
         instr_opcode <= code_byte;
         instr_len <= dec_len;
         instr_cycles <= dec_cycles;
         instr_class <= dec_cls;
         instr_known <= dec_known;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Operand bytes in fetch order
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         instr_operand1 <= cit_pkg::RESET_BYTE;
         instr_operand2 <= cit_pkg::RESET_BYTE;
      end else if (operand_fetch) begin
         // First operand arrives while all but none remain
         if (byte_left == instr_len - cit_pkg::LEN_1) begin
            instr_operand1 <= code_byte;
         end else begin
            instr_operand2 <= code_byte;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Progress pulses, each one clock after the event
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         instr_start <= 1'b0;
         instr_done <= 1'b0;
      end else begin
         instr_start <= (state == cit_pkg::ST_OPCODE);
         instr_done <= last_cycle;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data pointer: high byte arrives first, then low byte
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         data_pointer <= cit_pkg::RESET_POINTER;
      end else if (state == cit_pkg::ST_OPCODE && code_byte == cit_pkg::OP_PTR_INC) begin
         // Single clock increment, wraps at the top
         data_pointer <= data_pointer + cit_pkg::ADDR_STEP;
      end else if (operand_fetch && cur_cls == cit_pkg::CL_PTR_LOAD) begin
         if (byte_left == cit_pkg::LEN_2) begin
            data_pointer[15:8] <= code_byte;
         end else begin
            data_pointer[7:0] <= code_byte;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Accumulator load from code table or external read
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         acc_load <= 1'b0;
         acc_load_data <= cit_pkg::RESET_BYTE;
      end else if (state == cit_pkg::ST_EXEC && cycle_index == cit_pkg::STEP_ACCESS &&
                   (cur_cls == cit_pkg::CL_CODE_PTR || cur_cls == cit_pkg::CL_CODE_PC)) begin
         acc_load <= 1'b1;
         acc_load_data <= code_byte;
      end else if (state == cit_pkg::ST_EXEC && cycle_index == cit_pkg::STEP_ACCESS &&
                   (cur_cls == cit_pkg::CL_XRD_IDX || cur_cls == cit_pkg::CL_XRD_PTR)) begin
         // Read data is taken while the read strobe stands
         acc_load <= 1'b1;
         acc_load_data <= xdata_rdata;
      end else begin
         acc_load <= 1'b0;
      end
   end

endmodule : cit_sequencer

// >>> cit_pkg.sv
// Shared constants and types for the instruction timing sequencer
package cit_pkg;

   // Instruction lengths in bytes
   localparam logic [1:0] LEN_1 = 2'h1;
   localparam logic [1:0] LEN_2 = 2'h2;
   localparam logic [1:0] LEN_3 = 2'h3;

   // Execution times in system clocks
   localparam logic [3:0] CYC_1 = 4'h1;
   localparam logic [3:0] CYC_2 = 4'h2;
   localparam logic [3:0] CYC_3 = 4'h3;
   localparam logic [3:0] CYC_4 = 4'h4;
   localparam logic [3:0] CYC_8 = 4'h8;

   // Cycle index within one instruction
   localparam logic [3:0] STEP_FIRST = 4'h1;
   localparam logic [3:0] STEP_ACCESS = 4'h2;

   // Address arithmetic and reset values
   localparam logic [15:0] ADDR_STEP = 16'h0001;
   localparam logic [15:0] RESET_PC = 16'h0000;
   localparam logic [15:0] RESET_POINTER = 16'h0000;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] PAGE_ZERO = 8'h00;

   // Opcodes that carry a side effect in this block
   localparam logic [7:0] OP_PTR_INC = 8'ha3;

   // Instruction classes as the sequencer sees them
   typedef enum logic [3:0] {
      CL_UNKNOWN = 4'h0,
      CL_PLAIN = 4'h1,
      CL_PTR_LOAD = 4'h2,
      CL_PTR_INC = 4'h3,
      CL_CODE_PTR = 4'h4,
      CL_CODE_PC = 4'h5,
      CL_XRD_IDX = 4'h6,
      CL_XRD_PTR = 4'h7,
      CL_XWR_IDX = 4'h8,
      CL_XWR_PTR = 4'h9
   } cit_class_t;

   // Sequencer states, one-hot
   typedef enum logic [1:0] {
      ST_OPCODE = 2'b01,
      ST_EXEC = 2'b10
   } cit_state_t;

endpackage : cit_pkg

// >>> cit_opcode_decode.sv
// Opcode to length, clock count and class decoder
`timescale 1ns/1ps
module cit_opcode_decode (
   // Opcode under decode
   input wire logic [7:0] opcode,
   // Decoded timing
   output logic [1:0] len,
   output logic [3:0] cycles,
   output cit_pkg::cit_class_t cls,
   output logic known
);

   // Unknown opcodes fall back to one byte, one clock
   assign known = (cls != cit_pkg::CL_UNKNOWN);

   ////////////////////////////////////////////////////////////////////////////
   // Lookup by opcode pattern
   always_comb begin
      len = cit_pkg::LEN_1;
      cycles = cit_pkg::CYC_1;
      cls = cit_pkg::CL_PLAIN;
      casez (opcode)
         // Single clock: bank register, accumulator, carry
         8'b0010_1???, 8'b0011_1???, 8'b0100_1???, 8'b0101_1???, 8'b0110_1???,
         8'b1001_1???, 8'b000?_1???, 8'he4, 8'hf4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hc4,
         8'h04, 8'h14, 8'hd4, 8'hc3, 8'hd3, 8'hb3,
         8'b1110_1???, 8'b1111_1???, 8'b1100_1???: cls = cit_pkg::CL_PLAIN;
         // Two bytes, two clocks
         8'b0010_010?, 8'b0011_010?, 8'b0100_010?, 8'b0101_010?, 8'b0110_010?,
         8'b1001_010?, 8'h05, 8'h15, 8'he5, 8'h74, 8'hc5, 8'b010?0010, 8'h62,
         8'b1010_1???, 8'b0111_1???, 8'hf5, 8'b1000_1???, 8'b1010011?, 8'b0111011?,
         8'hc0, 8'hd0, 8'hc2, 8'hd2, 8'b1000011?: begin
            len = cit_pkg::LEN_2;
            cycles = cit_pkg::CYC_2;
         end
         // One byte, two clocks: indirect operand
         8'b0010011?, 8'b0011011?, 8'b0100011?, 8'b0101011?, 8'b0110011?, 8'b1001011?,
         8'b000?011?, 8'b1110011?, 8'b1111011?, 8'b1100011?, 8'b1101011?:
            cycles = cit_pkg::CYC_2;
         // Three bytes, three clocks
         8'b010?0011, 8'h63, 8'h85, 8'h75: begin
            len = cit_pkg::LEN_3;
            cycles = cit_pkg::CYC_3;
         end
         // Data pointer load and increment
         8'h90: begin
            len = cit_pkg::LEN_3;
            cycles = cit_pkg::CYC_3;
            cls = cit_pkg::CL_PTR_LOAD;
         end
         8'ha3: cls = cit_pkg::CL_PTR_INC;
         // Multiply and divide
         8'ha4: cycles = cit_pkg::CYC_4;
         8'h84: cycles = cit_pkg::CYC_8;
         // Code byte moves
         8'h93: begin
            cycles = cit_pkg::CYC_3;
            cls = cit_pkg::CL_CODE_PTR;
         end
         8'h83: begin
            cycles = cit_pkg::CYC_3;
            cls = cit_pkg::CL_CODE_PC;
         end
         // External data moves
         8'he0: begin
            cycles = cit_pkg::CYC_3;
            cls = cit_pkg::CL_XRD_PTR;
         end
         8'b1110_001?: begin
            cycles = cit_pkg::CYC_3;
            cls = cit_pkg::CL_XRD_IDX;
         end
         8'hf0: begin
            cycles = cit_pkg::CYC_3;
            cls = cit_pkg::CL_XWR_PTR;
         end
         8'b1111_001?: begin
            cycles = cit_pkg::CYC_3;
            cls = cit_pkg::CL_XWR_IDX;
         end
         // Outside this decoder's coverage
         default: cls = cit_pkg::CL_UNKNOWN;
      endcase
   end

endmodule : cit_opcode_decode

// >>> cit_xdata_port.sv
// Request stage toward the external memory interface
`timescale 1ns/1ps
module cit_xdata_port (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Request from the sequencer
   input wire logic start,
   input wire logic write,
   input wire logic wide,
   input wire logic [7:0] idx_value,
   input wire logic [15:0] pointer,
   input wire logic [7:0] wdata_in,
   // External memory interface
   output logic [15:0] xdata_addr,
   output logic xdata_rd,
   output logic xdata_wr,
   output logic [7:0] xdata_wdata
);

   ////////////////////////////////////////////////////////////////////////////
   // One clock strobes; address and data held
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         xdata_rd <= 1'b0;
         xdata_wr <= 1'b0;
         xdata_addr <= cit_pkg::RESET_POINTER;
         xdata_wdata <= cit_pkg::RESET_BYTE;
      end else begin
         xdata_rd <= start & ~write;
         xdata_wr <= start & write;
         // Narrow form sits in page zero
         if (start) begin
            xdata_addr <= wide ? pointer : {cit_pkg::PAGE_ZERO, idx_value};
            xdata_wdata <= wdata_in;
         end
      end
   end

endmodule : cit_xdata_port

// >>> cit_mem_model.sv
// Program and external data memory model facing the sequencer
`timescale 1ns/1ps
module cit_mem_model (
   // Clock
   input wire logic clk,
   // Program memory side
   input wire logic [15:0] code_addr,
   input wire logic code_rd,
   output logic [7:0] code_byte,
   // External data side
   input wire logic [15:0] xdata_addr,
   input wire logic xdata_rd,
   output logic [7:0] xdata_rdata
);
   logic [7:0] mem [0:255]; // Code image, wraps every 256 bytes
   logic [7:0] last_code = 8'h00; // Last byte handed out
   logic [7:0] last_x = 8'h00; // Last external byte handed out
   ////////////////////
   // Idle lines show the inverse of the last byte
   always_comb code_byte = code_rd ? mem[code_addr[7:0]] : ~last_code;
   always_comb xdata_rdata = xdata_rd ? (xdata_addr[7:0] ^ xdata_addr[15:8] ^ 8'ha5) : ~last_x;
   // Remember what was last driven
   always @(posedge clk) begin
      if (code_rd) last_code <= code_byte;
      if (xdata_rd) last_x <= xdata_rdata;
   end
endmodule : cit_mem_model

// >>> cit_sequencer_props.sv
// Timing assertions on the sequencer's ports
`timescale 1ns/1ps
module cit_sequencer_props (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Observed outputs
   input wire logic [15:0] code_addr,
   input wire logic code_rd,
   input wire logic xdata_rd,
   input wire logic xdata_wr,
   input wire logic [7:0] instr_opcode,
   input wire logic [1:0] instr_len,
   input wire logic [3:0] instr_cycles,
   input cit_pkg::cit_class_t instr_class,
   input wire logic instr_start,
   input wire logic instr_done,
   input wire logic [15:0] data_pointer,
   input wire logic acc_load
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_one_clk; instr_start && instr_cycles == cit_pkg::CYC_1 |-> instr_done; endproperty
   a_one_clk: assert property (p_one_clk) else $error("one clock op overran");
   property p_two_clk;
      instr_start && instr_cycles == cit_pkg::CYC_2 |-> !instr_done ##1 instr_done;
   endproperty
   a_two_clk: assert property (p_two_clk) else $error("two clock op mistimed");
   property p_three_clk;
      instr_start && instr_cycles == cit_pkg::CYC_3 |-> !instr_done [*2] ##1 instr_done;
   endproperty
   a_three_clk: assert property (p_three_clk) else $error("three clock op mistimed");
   property p_len3;
      instr_start && instr_len == cit_pkg::LEN_3 |->
         code_rd ##1 code_rd && code_addr == $past(code_addr) + cit_pkg::ADDR_STEP;
   endproperty
   a_len3: assert property (p_len3) else $error("operand fetch not consecutive");
   property p_ptr_inc;
      instr_start && instr_opcode == cit_pkg::OP_PTR_INC |->
         data_pointer == $past(data_pointer) + cit_pkg::ADDR_STEP;
   endproperty
   a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not incremented");
   property p_code_move;
      instr_start && (instr_class == cit_pkg::CL_CODE_PTR || instr_class == cit_pkg::CL_CODE_PC)
         |-> code_rd ##1 (acc_load && !code_rd) ##1 instr_done;
   endproperty
   a_code_move: assert property (p_code_move) else $error("code byte move mistimed");
   property p_xread; xdata_rd |-> !code_rd ##1 acc_load ##1 instr_done; endproperty
   a_xread: assert property (p_xread) else $error("external read mistimed");
   property p_xwrite; xdata_wr |-> !code_rd ##1 !acc_load ##1 instr_done; endproperty
   a_xwrite: assert property (p_xwrite) else $error("external write mistimed");
   property p_next_fetch; instr_done |-> code_rd; endproperty
   a_next_fetch: assert property (p_next_fetch) else $error("no opcode fetch after op");
   // Main scenarios
   c_xread: cover property (xdata_rd);
   c_xwrite: cover property (xdata_wr);
   c_load: cover property (acc_load);
   c_three: cover property (instr_start && instr_cycles == cit_pkg::CYC_3);
endmodule : cit_sequencer_props
bind cit_sequencer cit_sequencer_props cit_sequencer_props_inst (.clk(clk), .sys_rst(sys_rst),
   .code_addr(code_addr), .code_rd(code_rd), .xdata_rd(xdata_rd), .xdata_wr(xdata_wr),
   .instr_opcode(instr_opcode), .instr_len(instr_len), .instr_cycles(instr_cycles),
   .instr_class(instr_class), .instr_start(instr_start), .instr_done(instr_done),
   .data_pointer(data_pointer), .acc_load(acc_load));

// >>> tb_top.sv
// Self-checking bench for the instruction timing sequencer
`timescale 1ns/1ps
module tb_top;
   typedef struct {
      logic [7:0] op;
      logic [3:0] len;
      logic [3:0] cyc;
      logic [15:0] pc;
      logic [15:0] dpb;
      logic [15:0] dpa;
   } cit_exp_t; // Expected op
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] acc_value = 8'h00;
   logic [7:0] idx_value = 8'h00;
   logic [15:0] code_addr, xdata_addr, data_pointer;
   logic code_rd, xdata_rd, xdata_wr, instr_known, instr_start, instr_done, acc_load;
   logic [7:0] code_byte, xdata_rdata, xdata_wdata, instr_opcode, acc_load_data;
   logic [1:0] instr_len;
   logic [3:0] instr_cycles;
   cit_pkg::cit_class_t instr_class;
   logic [31:0] seed = 32'h0000002a; // Xorshift state
   logic [7:0] prog [0:255]; // Bench copy of the code image
   cit_exp_t q [$];
   cit_exp_t cur;
   int fail_count = 0;
   int checked = 0;
   int cnt = 0;
   bit busy = 0;
   bit act = 0;
   logic [7:0] pacc, pidx; // Datapath values of the opcode cycle
   logic [15:0] xa;
   // Opcode, bytes, clocks of each form
   logic [15:0] tbl [0:27] = '{16'h2811, 16'h3522, 16'h9612, 16'h5422, 16'h4333, 16'h6222,
      16'he411, 16'hd411, 16'hc411, 16'h0311, 16'h8533, 16'h9033, 16'ha311, 16'h9313,
      16'h8313, 16'he013, 16'he213, 16'hf013, 16'hf313, 16'hc022, 16'hd022, 16'hc612,
      16'hd712, 16'hc911, 16'hf612, 16'ha622, 16'h7622, 16'h8622};
   ////////////////////
   cit_sequencer cit_sequencer_inst (.clk(clk), .sys_rst(sys_rst), .code_addr(code_addr),
      .code_rd(code_rd), .code_byte(code_byte), .acc_value(acc_value), .idx_value(idx_value),
      .xdata_addr(xdata_addr), .xdata_rd(xdata_rd), .xdata_wr(xdata_wr),
      .xdata_wdata(xdata_wdata), .xdata_rdata(xdata_rdata), .instr_opcode(instr_opcode),
      .instr_operand1(), .instr_operand2(), .instr_len(instr_len), .instr_cycles(instr_cycles),
      .instr_class(instr_class), .instr_known(instr_known), .instr_start(instr_start),
      .instr_done(instr_done), .cycle_index(), .data_pointer(data_pointer),
      .acc_load(acc_load), .acc_load_data(acc_load_data));
   cit_mem_model cit_mem_model_inst (.clk(clk), .code_addr(code_addr), .code_rd(code_rd),
      .code_byte(code_byte), .xdata_addr(xdata_addr), .xdata_rd(xdata_rd),
      .xdata_rdata(xdata_rdata));
   ////////////////////
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk_val
   task automatic chk_bit(input string what, input logic exp, input logic got);
      chk_val(what, {15'h0000, exp}, {15'h0000, got});
   endtask : chk_bit
   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   // Random program; trailing bytes go unchecked
   task automatic gen_prog(input int n);
      int a;
      cit_exp_t e;
      logic [15:0] dp;
      a = 0;
      dp = 16'h0000;
      q.delete();
      for (int i = 0; i < 256; i++) prog[i] = 8'(rnd());
      for (int i = 0; i < n; i++) begin
         e.op = tbl[rnd() % 28][15:8];
         for (int k = 0; k < 28; k++) if (tbl[k][15:8] == e.op) {e.len, e.cyc} = tbl[k][7:0];
         e.pc = 16'(a);
         e.dpb = dp;
         prog[a] = e.op;
         if (e.op == 8'h90) dp = {prog[a+1], prog[a+2]};
         if (e.op == 8'ha3) dp = dp + 16'h0001;
         e.dpa = dp;
         q.push_back(e);
         a += e.len;
      end
      cit_mem_model_inst.mem = prog;
   endtask : gen_prog
   ////////////////////
   initial forever #2.5 clk = ~clk;
   // Datapath values change every clock
   always @(posedge clk) begin
      acc_value <= 8'(rnd());
      idx_value <= 8'(rnd());
   end
   // Model compared at every instruction
   always @(negedge clk) begin
      if (act && !sys_rst) begin
         if (instr_start === 1'b1 && q.size() != 0) begin
            cur = q.pop_front();
            busy = 1;
            cnt = 1;
            chk_val("opcode", cur.op, instr_opcode);
            chk_val("length", cur.len, instr_len);
            chk_val("clock count", cur.cyc, instr_cycles);
            chk_bit("known", 1'b1, instr_known);
            xa = cur.dpb + {8'h00, pacc};
            if (cur.op == 8'h83) xa = cur.pc + 16'h0001 + {8'h00, pacc};
            if (cur.op inside {8'he0, 8'hf0}) xa = cur.dpb;
            if (cur.op inside {8'he2, 8'hf3}) xa = {8'h00, pidx};
            if (cur.op inside {8'h93, 8'h83}) chk_val("code address", xa, code_addr);
            if (cur.op inside {8'he0, 8'he2, 8'hf0, 8'hf3})
               chk_val("external address", xa, xdata_addr);
            if (cur.op inside {8'he0, 8'he2}) chk_bit("external read", 1'b1, xdata_rd);
            if (cur.op inside {8'hf0, 8'hf3}) chk_bit("external write", 1'b1, xdata_wr);
            if (cur.op inside {8'hf0, 8'hf3}) chk_val("write data", pacc, xdata_wdata);
         end else if (busy) cnt++;
         if (busy && cnt == 2 && cur.op inside {8'h93, 8'h83, 8'he0, 8'he2}) begin
            chk_bit("load pulse", 1'b1, acc_load);
            chk_val("load data", cur.op[7:4] == 4'he ? (xa[7:0] ^ xa[15:8] ^ 8'ha5)
               : prog[xa[7:0]], acc_load_data);
         end
         if (busy && instr_done === 1'b1) begin
            chk_val("clocks taken", cur.cyc, 16'(cnt));
            chk_val("next fetch", cur.pc + cur.len, code_addr);
            chk_val("data pointer", cur.dpa, data_pointer);
            busy = 0;
         end
      end
      pacc = acc_value;
      pidx = idx_value;
   end
   // Three programs, later resets hit a running core
   initial begin
      for (int t = 0; t < 3; t++) begin
         @(posedge clk);
         sys_rst <= 1'b1;
         act = 0;
         busy = 0;
         repeat (4) @(posedge clk);
         chk_val("reset address", 16'h0000, code_addr);
         chk_val("reset pointer", 16'h0000, data_pointer);
         gen_prog(40);
         act = 1;
         sys_rst <= 1'b0;
         for (int c = 0; c < 2000 && (q.size() != 0 || busy); c++) @(negedge clk);
         chk_val("ops left", 16'h0000, 16'(q.size()));
         $display("test %0d ended", t);
      end
      report_and_stop();
   end
   // Hang guard, well past the expected run
   initial begin
      #40000;
      fail_count++;
      report_and_stop();
   end
endmodule : tb_top
